// [logic/occ_pkg.sv]
// Purpose: constants and types for the output compare control block
// Assumes: axi4-lite register bus, 32-bit data, one word per register
// Notes: control register keeps the 16-bit layout in the low half
package occ_pkg;
  // register byte offsets
  localparam logic [7:0] OCC_CTRL_OFF = 8'h00;
  localparam logic [7:0] OCC_PRIM_OFF = 8'h04;
  localparam logic [7:0] OCC_SEC_OFF = 8'h08;
  localparam logic [7:0] OCC_STAT_OFF = 8'h0c;
  localparam logic [7:0] OCC_MASK_OFF = 8'h10;
  // control field positions
  localparam int OCC_IDLE_BIT = 13;
  localparam int OCC_FLT_BIT = 4;
  localparam int OCC_TSEL_BIT = 3;
  localparam int OCC_MODE_LSB = 0;
  // status bit positions
  localparam int OCC_ST_RISE = 0;
  localparam int OCC_ST_FALL = 1;
  localparam int OCC_ST_FAULT = 2;
  // reset values
  localparam logic [15:0] OCC_CTRL_RST = 16'h0000;
  localparam logic [15:0] OCC_CMP_RST = 16'h0000;
  localparam logic [2:0] OCC_IRQ_RST = 3'h0;
  localparam logic [1:0] OCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OCC_M_OFF = 3'b000,
    OCC_M_LOW1 = 3'b001,
    OCC_M_HIGH1 = 3'b010,
    OCC_M_TOGGLE = 3'b011,
    OCC_M_DELAY1 = 3'b100,
    OCC_M_CONT = 3'b101,
    OCC_M_PWM = 3'b110,
    OCC_M_PWMF = 3'b111
  } occ_mode_t;
endpackage

// [logic/occ_top.sv]
// Purpose: output compare channel control, registers over axi4-lite
// Assumes: timer counts arrive on aclk; idle and fault arrive from pins
// Notes: each edge of the compare pin that the mode names raises an event
// Notes: the fault flag is cleared by hardware only, when the mode leaves 111; rewriting 111 keeps it
// Behaviour
// - with idle stop set the channel freezes during cpu idle, otherwise it runs on.
// - a fault sets the fault flag and only hardware clears it, never a bus write.
// - the fault flag only has meaning in pwm-with-fault mode.
// - the timebase select bit picks timer three when 1 and timer two when 0.
// - mode 000 hands the pin to gpio, 001/100/101 start low, 010 high, with the listed interrupt edges.
// - toggle mode inverts the pin each compare, keeps its level on entry, and interrupts on both edges.
// - pwm modes start low if the primary value is zero else high, and mode 110 never interrupts.
// - in mode 111 a falling edge of fault input a raises the interrupt.
`timescale 1ns/1ps
module occ_top
  import occ_pkg::*;
(
  input wire logic aclk, // 250 mhz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [15:0] timebase_two, // timer two count
  input wire logic [15:0] timebase_three, // timer three count
  input wire logic [15:0] period_two, // timer two period
  input wire logic [15:0] period_three, // timer three period
  input wire logic cpu_idle, // cpu idle level, async
  input wire logic fault_input_a, // fault pin, async
  output logic compare_output_pin, // compare output value
  output logic compare_output_en, // high while channel owns the pin
  output logic irq, // level interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // all state of the channel and its bus slave in one record
  typedef struct packed {
    logic [1:0] idle_sync;
    logic [2:0] flt_sync;
    logic [15:0] ctrl;
    logic [15:0] prim;
    logic [15:0] sec;
    logic [2:0] stat;
    logic [2:0] mask;
    logic pin;
    logic en;
    logic done;
    logic [2:0] last_mode;
    logic irq;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } occ_state_t;

  // present and next state
  occ_state_t s;
  occ_state_t next_s;

  // byte-enable merge of a 16-bit register
  // bytes 2 and 3 of the bus word are ignored, the registers are 16 bits
  function automatic logic [15:0] occ_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    occ_merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // known offsets answer okay, anything else slverr
  function automatic logic occ_hit(input logic [7:0] a);
    occ_hit = (a == OCC_CTRL_OFF) || (a == OCC_PRIM_OFF) || (a == OCC_SEC_OFF) ||
              (a == OCC_STAT_OFF) || (a == OCC_MASK_OFF);
  endfunction

  // decoded channel controls and bus strobes
  logic [15:0] tcount;
  logic [15:0] tperiod;
  occ_mode_t mode;
  logic run;
  logic hit_prim;
  logic hit_sec;
  logic pin_rise;
  logic pin_fall;
  logic flt_fall;
  logic do_wr;
  logic do_rd;
  logic [2:0] ev;
  logic [15:0] ctrl_wr;
  logic new_mode;

  // timebase choice and channel decode
  // idle stop freezes the compare engine only; the register bus keeps answering
  always_comb begin
    tcount = s.ctrl[OCC_TSEL_BIT] ? timebase_three : timebase_two;
    tperiod = s.ctrl[OCC_TSEL_BIT] ? period_three : period_two;
    mode = occ_mode_t'(s.ctrl[OCC_MODE_LSB +: 3]);
    run = !(s.ctrl[OCC_IDLE_BIT] && s.idle_sync[1]);
    hit_prim = run && (tcount == s.prim);
    hit_sec = run && (tcount == s.sec);
    // synchroniser first stage is left alone, edges use stages 1 and 2
    flt_fall = s.flt_sync[2] && !s.flt_sync[1];
    do_wr = s.aw_hold && s.w_hold && !s.bvalid;
    do_rd = s_axi_arvalid && !s.rvalid;
    new_mode = (mode != occ_mode_t'(s.last_mode));
  end

  always_comb begin
    next_s = s;
    next_s.idle_sync = {s.idle_sync[0], cpu_idle};
    next_s.flt_sync = {s.flt_sync[1:0], fault_input_a};
    next_s.last_mode = mode;
    // compare engine per mode
    // 001 and 010 fire once at the primary match, then sit until the mode is changed
    // 100 rises at the primary match and falls at the secondary match, once
    // 101 repeats that pulse on every pass of the timer
    // 011 flips the pin on each primary match and never reloads it
    // 110 and 111 rise at the period match and fall at the secondary match
    // the timer is expected to hold each count for at least one clock
    if (new_mode) begin
      next_s.done = 1'b0;
      case (mode)
        OCC_M_OFF: next_s.en = 1'b0;
        OCC_M_LOW1, OCC_M_DELAY1, OCC_M_CONT: begin
          next_s.en = 1'b1;
          next_s.pin = 1'b0;
        end
        OCC_M_HIGH1: begin
          next_s.en = 1'b1;
          next_s.pin = 1'b1;
        end
        OCC_M_TOGGLE: next_s.en = 1'b1;
        default: begin
          next_s.en = 1'b1;
          next_s.pin = (s.prim != 16'h0000);
        end
      endcase
    end else if (run) begin
      case (mode)
        OCC_M_OFF: next_s.en = 1'b0;
        OCC_M_LOW1: if (hit_prim && !s.done) begin
          next_s.pin = 1'b1;
          next_s.done = 1'b1;
        end
        OCC_M_HIGH1: if (hit_prim && !s.done) begin
          next_s.pin = 1'b0;
          next_s.done = 1'b1;
        end
        OCC_M_TOGGLE: if (hit_prim) next_s.pin = !s.pin;
        OCC_M_DELAY1: begin
          if (hit_prim && !s.done) next_s.pin = 1'b1;
          else if (hit_sec && s.pin) begin
            next_s.pin = 1'b0;
            next_s.done = 1'b1;
          end
        end
        OCC_M_CONT: begin
          if (hit_prim) next_s.pin = 1'b1;
          else if (hit_sec) next_s.pin = 1'b0;
        end
        OCC_M_PWM: begin
          if (tcount == tperiod) next_s.pin = (s.sec != 16'h0000);
          else if (hit_sec) next_s.pin = 1'b0;
        end
        default: begin
          // fault forces the pin low until the mode is changed
          if (s.ctrl[OCC_FLT_BIT]) next_s.pin = 1'b0;
          else if (tcount == tperiod) next_s.pin = (s.sec != 16'h0000);
          else if (hit_sec) next_s.pin = 1'b0;
        end
      endcase
    end
    // pin edge events per mode
    // the cycle that loads the initial level raises no event, whatever the pin does
    pin_rise = next_s.pin && !s.pin && s.en && !new_mode;
    pin_fall = !next_s.pin && s.pin && s.en && !new_mode;
    ev = 3'h0;
    case (mode)
      OCC_M_LOW1: ev[OCC_ST_RISE] = pin_rise;
      OCC_M_HIGH1, OCC_M_DELAY1, OCC_M_CONT: ev[OCC_ST_FALL] = pin_fall;
      OCC_M_TOGGLE: begin
        ev[OCC_ST_RISE] = pin_rise;
        ev[OCC_ST_FALL] = pin_fall;
      end
      OCC_M_PWMF: ev[OCC_ST_FAULT] = flt_fall && run;
      default: ev = 3'h0;
    endcase
    // write channel capture, either order
    // address and data are each parked in a holding slot until both are in,
    // so the master may offer them in any order and at any spacing
    // a ready drops while its slot is full; the slot frees when the write is carried out
    if (s_axi_awvalid && !s.aw_hold) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_hold) begin
      next_s.w_hold = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    next_s.stat = s.stat;
    ctrl_wr = occ_merge(s.ctrl, s.w_data, s.w_strb);
    if (do_wr) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = occ_hit(s.aw_addr) ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
      if (s.aw_addr == OCC_CTRL_OFF) begin
        // fault flag is read-only, a write leaves it alone
        next_s.ctrl = {2'h0, ctrl_wr[OCC_IDLE_BIT], 8'h00, s.ctrl[OCC_FLT_BIT], ctrl_wr[3:0]};
        // writing a different mode is the hardware path that clears the fault
        if (ctrl_wr[OCC_MODE_LSB +: 3] != s.ctrl[OCC_MODE_LSB +: 3]) next_s.ctrl[OCC_FLT_BIT] = 1'b0;
      end else if (s.aw_addr == OCC_PRIM_OFF) begin
        next_s.prim = occ_merge(s.prim, s.w_data, s.w_strb);
      end else if (s.aw_addr == OCC_SEC_OFF) begin
        next_s.sec = occ_merge(s.sec, s.w_data, s.w_strb);
      end else if (s.aw_addr == OCC_STAT_OFF) begin
        if (s.w_strb[0]) next_s.stat = s.stat & ~s.w_data[2:0];
      end else if (s.aw_addr == OCC_MASK_OFF) begin
        if (s.w_strb[0]) next_s.mask = s.w_data[2:0];
      end
    end
    // set wins over clear
    next_s.stat = next_s.stat | ev;
    // fault latch only in pwm-with-fault mode
    // the set comes after the clears, so a fault in the cycle of a clear is not lost
    // outside mode 111 the flag is held clear, as it carries no meaning there
    if (mode == OCC_M_PWMF && flt_fall && run) next_s.ctrl[OCC_FLT_BIT] = 1'b1;
    if (mode != OCC_M_PWMF) next_s.ctrl[OCC_FLT_BIT] = 1'b0;
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    // read channel
    // one read at a time: arready stays low until the data beat is taken
    if (do_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = occ_hit(s_axi_araddr) ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
      if (s_axi_araddr == OCC_CTRL_OFF) next_s.rdata = {16'h0000, s.ctrl};
      else if (s_axi_araddr == OCC_PRIM_OFF) next_s.rdata = {16'h0000, s.prim};
      else if (s_axi_araddr == OCC_SEC_OFF) next_s.rdata = {16'h0000, s.sec};
      else if (s_axi_araddr == OCC_STAT_OFF) next_s.rdata = {29'h0, s.stat};
      else if (s_axi_araddr == OCC_MASK_OFF) next_s.rdata = {29'h0, s.mask};
      else next_s.rdata = 32'h0;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    // readies registered from the next holding state, so no output is combinational
    next_s.awrdy = !next_s.aw_hold;
    next_s.wrdy = !next_s.w_hold;
    next_s.arrdy = !next_s.rvalid;
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  // single state register
  // synchronous reset only; every field comes back to a constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= OCC_CTRL_RST;
      s.prim <= OCC_CMP_RST;
      s.sec <= OCC_CMP_RST;
      s.stat <= OCC_IRQ_RST;
      s.mask <= OCC_IRQ_RST;
      s.bresp <= OCC_RESP_OKAY;
      s.rresp <= OCC_RESP_OKAY;
      s.awrdy <= 1'b1;
      s.wrdy <= 1'b1;
      s.arrdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  // readies are registered too, so nothing combinational reaches a port
  always_comb begin
    compare_output_pin = s.pin;
    compare_output_en = s.en;
    irq = s.irq;
    s_axi_awready = s.awrdy;
    s_axi_wready = s.wrdy;
    s_axi_bvalid = s.bvalid;
    s_axi_bresp = s.bresp;
    s_axi_arready = s.arrdy;
    s_axi_rvalid = s.rvalid;
    s_axi_rdata = s.rdata;
    s_axi_rresp = s.rresp;
  end
endmodule

// [tb/occ_load.sv]
// Purpose: external load on the compare output
// Assumes: a pull-down on the board
// Notes: a released pin reads as the pull-down
`timescale 1ns/1ps
module occ_load (
  input wire logic pin, // pin value
  input wire logic en, // channel drives pin
  output logic level // level at the load
);
  // released pin falls low, never the last value
  assign level = en ? pin : 1'b0;
endmodule

// [tb/occ_props.sv]
// Purpose: port checks for occ_top
// Assumes: control writes offer address and data together
// Notes: mode and idle stop are snooped off the bus
`timescale 1ns/1ps
module occ_props
  import occ_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic cpu_idle, // idle
  input wire logic compare_output_pin, // pin
  input wire logic compare_output_en, // pin enable
  input wire logic [7:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // w data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid // r valid
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] mode;
  logic idle_st;
  wire aw_go = s_axi_awvalid && s_axi_awready;
  wire w_go = s_axi_wvalid && s_axi_wready;
  // snoop control writes; split phases are missed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= 3'h0;
      idle_st <= 1'b0;
    end else if (aw_go && w_go && s_axi_awaddr == OCC_CTRL_OFF) begin
      mode <= s_axi_wdata[2:0];
      idle_st <= s_axi_wdata[OCC_IDLE_BIT];
    end
  end
  property p_blat; aw_go && w_go |-> ##2 s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("write response late");
  property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bone: assert property (p_bone) else $error("write response repeated");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arrdy: assert property (p_arrdy) else $error("read address taken early");
  property p_awrdy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_awrdy: assert property (p_awrdy) else $error("write address slot not held");
  property p_en_off; (mode == 3'h0) [*5] |-> !compare_output_en; endproperty
  a_en_off: assert property (p_en_off) else $error("pin kept when off");
  property p_en_on; (mode != 3'h0) [*5] |-> compare_output_en; endproperty
  a_en_on: assert property (p_en_on) else $error("pin not taken");
  property p_idle; (idle_st && cpu_idle) [*5] |=> $stable(compare_output_pin); endproperty
  a_idle: assert property (p_idle) else $error("pin moved in idle");
endmodule
bind occ_top occ_props u_props (.*);

// [tb/tb.sv]
// Purpose: self-checking bench for occ_top
// Assumes: timers sit off every compare value unless pulsed
// Notes: reads are queued and checked by a monitor
`timescale 1ns/1ps
module tb;
  import occ_pkg::*;
  logic aclk, aresetn, cpu_idle, fault_input_a, compare_output_pin, compare_output_en, irq, load_level;
  logic [15:0] timebase_two, timebase_three, period_two, period_three, prim;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_q[$];
  logic [1:0] exp_b[$];
  int errors, n_tests, cyc_cnt;
  occ_top dut (.*);
  occ_load u_load (.pin(compare_output_pin), .en(compare_output_en), .level(load_level));
  // 4 ns clock
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task wrap_up();
    $display("checks=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cb(input logic g, input logic e);
    chk({33'h0, g}, {33'h0, e});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bready stays high, so the response is taken when seen
  task wr(input logic [7:0] a, input logic [31:0] d);
    exp_b.push_back((a inside {OCC_CTRL_OFF, OCC_PRIM_OFF, OCC_SEC_OFF, OCC_STAT_OFF, OCC_MASK_OFF}) ?
                    OCC_RESP_OKAY : OCC_RESP_SLVERR);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask
  task md(input logic [31:0] v);
    wr(OCC_CTRL_OFF, v);
    cyc(3);
  endtask
  // one cycle on the compare value, then back off it
  task pulse(input bit three);
    if (three) timebase_three <= prim;
    else timebase_two <= prim;
    cyc(1);
    timebase_two <= prim + 16'h1;
    timebase_three <= prim + 16'h3;
    cyc(4);
  endtask
  // read beats against the oldest note; counter cuts a hang
  always @(posedge aclk) begin
    cyc_cnt++;
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    if (cyc_cnt == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(83290));
    prim = 16'h10 + 16'($urandom % 32'hffe0);
    {aresetn, cpu_idle, fault_input_a} <= 3'h1;
    {timebase_two, timebase_three} <= {prim + 16'h1, prim + 16'h3};
    {period_two, period_three} <= {prim + 16'h2, prim + 16'h4};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} <= '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} <= 6'h3f;
    cyc(20);
    aresetn <= 1'b1;
    cyc(1);
    rd(OCC_CTRL_OFF, {18'h0, OCC_CTRL_RST});
    rd(8'h20, {OCC_RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h0);
    wr(OCC_PRIM_OFF, {16'h0, prim});
    wr(OCC_SEC_OFF, 32'h0);
    for (int m = 1; m < 6; m++) begin
      if (m == 3) continue;
      md(32'(m));
      cb(load_level, m == 2);
      cb(compare_output_en, 1'b1);
    end
    md(32'h0);
    cb(compare_output_en, 1'b0);
    md(32'h6);
    cb(load_level, 1'b1);
    md(32'h0);
    wr(OCC_PRIM_OFF, 32'h0);
    md(32'h6);
    cb(load_level, 1'b0);
    wr(OCC_PRIM_OFF, {16'h0, prim});
    md(32'h0);
    md(32'h6);
    wr(OCC_SEC_OFF, {16'h0, prim});
    wr(OCC_STAT_OFF, 32'h7);
    wr(OCC_MASK_OFF, 32'h7);
    pulse(0);
    cb(load_level, 1'b0);
    cb(irq, 1'b0);
    wr(OCC_SEC_OFF, 32'h0);
    md(32'h2);
    wr(OCC_STAT_OFF, 32'h7);
    wr(OCC_MASK_OFF, 32'h2);
    md(32'h3);
    cb(load_level, 1'b1);
    pulse(0);
    cb(load_level, 1'b0);
    cb(irq, 1'b1);
    rd(OCC_STAT_OFF, 34'h2);
    wr(OCC_STAT_OFF, 32'h2);
    cyc(2);
    cb(irq, 1'b0);
    md(32'h0b);
    pulse(0);
    cb(load_level, 1'b0);
    pulse(1);
    cb(load_level, 1'b1);
    md(32'h200b);
    cpu_idle <= 1'b1;
    cyc(4);
    pulse(1);
    cb(load_level, 1'b1);
    cpu_idle <= 1'b0;
    cyc(4);
    pulse(1);
    cb(load_level, 1'b0);
    md(32'h0b);
    cpu_idle <= 1'b1;
    cyc(4);
    pulse(1);
    cb(load_level, 1'b1);
    cpu_idle <= 1'b0;
    wr(OCC_STAT_OFF, 32'h7);
    wr(OCC_MASK_OFF, 32'h4);
    md(32'h7);
    fault_input_a <= 1'b0;
    cyc(6);
    fault_input_a <= 1'b1;
    cyc(2);
    cb(irq, 1'b1);
    rd(OCC_CTRL_OFF, 34'h17);
    wr(OCC_CTRL_OFF, 32'h7);
    rd(OCC_CTRL_OFF, 34'h17);
    md(32'h6);
    rd(OCC_CTRL_OFF, 34'h6);
    cyc(2);
    wrap_up();
  end
endmodule
